// ===== hdl/sodd_cdb_store.sv
`include "sodd_defs.svh"

module sodd_cdb_store #(
	parameter int N = `SODD_CDB_BYTES
) (
	// Clock and reset.
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Byte write side.
	input  wire logic             clear_in,
	input  wire logic             wr_in,
	input  wire logic [7:0]       byte_in,
	// Stored bytes, byte 0 in the low lane.
	output logic      [N*8-1:0]   cdb_out
);

	logic [N-1:0][7:0] mem_q;
	logic [7:0]        idx_q;

	// Bytes fill from index 0; extra bytes beyond N are dropped.
	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in) begin
			idx_q <= 8'h00;
		end else if (wr_in && idx_q < 8'(N)) begin
			mem_q[idx_q] <= byte_in;
			idx_q        <= idx_q + 8'h01;
		end
	end

	assign cdb_out = mem_q;

endmodule : sodd_cdb_store

// ===== hdl/sodd_decoder.sv
// Summary of operation
// - Opcode B5h forwards parameter list to protocol.
// - Protocols 01h-06h valid; 00h and 07h and above reserved.
// - Block flag counts 512-byte units, zero padded.
// - Otherwise bytes 6-9 give exact byte count.
// - Good status early or after processing, per protocol.
// - Opcode 1Dh decodes self-diagnostic byte 1 fields.
// - Page format ignored when default test set.
// - Default test flag overrides the function code.
// - Codes 001b, 010b start background tests.
// - Codes 101b, 110b start foreground tests.
// - Code 100b aborts running background test.
// - Both offline flags are ignored.
// - Default test needs zero parameter list length.
// - Page length mismatch gives invalid field.
// - Wrong spindle speed gives not ready.
// - Default or foreground fault ends in check.
// - Background fault goes to the test log.
// - Empty page zero requests supported page list.
// - Security results ending good before status held until read, reset or nexus loss.
`include "sodd_defs.svh"

module sodd_decoder #(
	parameter int          NEXUS_W         = 8,
	parameter logic [39:0] FG_SHORT_CYCLES = 40'(`SODD_FG_SHORT_S * `SODD_CLK_HZ)
) (
	// Clock and reset.
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	// Command block bytes.
	input  wire logic               cdb_valid_in,
	input  wire logic [7:0]         cdb_byte_in,
	input  wire logic               cdb_last_in,
	input  wire logic [NEXUS_W-1:0] cdb_nexus_in,
	// Data out phase.
	input  wire logic               dout_valid_in,
	input  wire logic [7:0]         dout_byte_in,
	output logic                    dout_ready_out,
	// Command status.
	output logic                    status_valid_out,
	output logic                    status_check_out,
	output logic [3:0]              sense_key_out,
	output logic [7:0]              asc_out,
	// Security protocol handler.
	output logic                    sec_start_out,
	output logic [7:0]              sec_proto_out,
	output logic [40:0]             sec_len_out,
	output logic                    sec_byte_valid_out,
	output logic [7:0]              sec_byte_out,
	input  wire logic               sec_early_good_in,
	input  wire logic               sec_done_in,
	input  wire logic               sec_ok_in,
	// Security result retention.
	input  wire logic               result_read_in,
	input  wire logic [NEXUS_W-1:0] read_nexus_in,
	input  wire logic               lun_reset_in,
	input  wire logic               nexus_loss_in,
	input  wire logic [NEXUS_W-1:0] loss_nexus_in,
	output logic                    sec_result_held_out,
	// Self-test engine.
	input  wire logic               spindle_ok_in,
	output logic                    st_start_out,
	output sodd_pkg::sodd_test_e    st_kind_out,
	output logic                    st_background_out,
	output logic                    st_abort_out,
	input  wire logic               st_done_in,
	input  wire logic               st_fault_in,
	output logic                    bg_busy_out,
	output logic                    log_valid_out,
	output sodd_pkg::sodd_test_e    log_kind_out,
	// Supported pages request.
	input  wire logic               rcv_diag_in,
	output logic                    pages_pending_out
);

	sodd_pkg::sodd_state_e state_q;
	logic [`SODD_CDB_BYTES*8-1:0] cdb;
	logic [7:0]   b1;
	logic [7:0]   op;
	logic [2:0]   fc;
	logic         selftest;
	logic [15:0]  plen;
	logic [31:0]  tlen;
	logic [40:0]  xfer_len;
	logic         bad;
	logic [3:0]   bad_sk;
	logic [7:0]   bad_asc;
	logic         spin_meta_q;
	logic         spin_ok_q;
	logic [40:0]  remain_q;
	logic [15:0]  didx_q;
	logic [7:0]   page_code_q;
	logic [15:0]  page_len_q;
	logic [2:0]   fc_q;
	logic         bg_busy_q;
	logic [39:0]  fg_cnt_q;
	logic         fg_short_q;
	logic [NEXUS_W-1:0] nexus_q;
	logic [NEXUS_W-1:0] held_nexus_q;
	logic         page_match;
	logic         dacc;

	// Returns byte n of the stored command block.
	function automatic logic [7:0] cdb_b(input int n);
		cdb_b = cdb[n*8 +: 8];
	endfunction : cdb_b

	// True for reserved security protocol values.
	function automatic logic proto_reserved(input logic [7:0] p);
		proto_reserved = (p < `SODD_PROTO_FIRST) || (p > `SODD_PROTO_LAST);
	endfunction : proto_reserved

	// True for reserved diagnostic function codes.
	function automatic logic fc_reserved(input logic [2:0] f);
		fc_reserved = (f == `SODD_FC_RSVD_A) || (f == `SODD_FC_RSVD_B);
	endfunction : fc_reserved

	// Command block bytes live in their own store.
	sodd_cdb_store #(
		.N        (`SODD_CDB_BYTES)
	) u_store (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.clear_in (state_q == sodd_pkg::ST_STATUS),
		.wr_in    (cdb_valid_in && state_q == sodd_pkg::ST_IDLE),
		.byte_in  (cdb_byte_in),
		.cdb_out  (cdb)
	);

	// Spindle speed comes from a pin and is synchronised first.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			spin_meta_q <= 1'b0;
			spin_ok_q   <= 1'b0;
		end else begin
			spin_meta_q <= spindle_ok_in;
			spin_ok_q   <= spin_meta_q;
		end
	end

	// Field decode and up-front checks of a complete command block.
	always_comb begin
		op       = cdb_b(0);
		b1       = cdb_b(1);
		fc       = b1[`SODD_FC_HI:`SODD_FC_LO];
		selftest = b1[`SODD_SELFTEST_BIT];
		plen     = {cdb_b(3), cdb_b(4)};
		tlen     = {cdb_b(6), cdb_b(7), cdb_b(8), cdb_b(9)};
		xfer_len = cdb[4*8 + `SODD_INC512_BIT] ?
			{tlen, 9'h000} : {9'h000, tlen};
		bad      = 1'b0;
		bad_sk   = `SODD_SK_ILLEGAL;
		bad_asc  = `SODD_ASC_INV_CDB;
		if (op == `SODD_OP_SEC_OUT) begin
			bad = proto_reserved(b1);
		end else if (op == `SODD_OP_DIAG) begin
			if (!spin_ok_q) begin
				bad     = 1'b1;
				bad_sk  = `SODD_SK_NOT_READY;
				bad_asc = `SODD_ASC_NOT_READY;
			end else if (selftest) begin
				bad = (plen != 16'h0000);
			end else if (fc_reserved(fc)) begin
				bad = 1'b1;
			end else if (fc == `SODD_FC_ABORT && !bg_busy_q) begin
				bad = 1'b1;
			end
		end else begin
			bad     = 1'b1;
			bad_asc = `SODD_ASC_INV_OP;
		end
	end

	assign page_match = ({1'b0, didx_q} == {1'b0, page_len_q} + `SODD_PAGE_HDR);
	assign dacc       = dout_valid_in && dout_ready_out;

	// Command sequencer and status codes.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q          <= sodd_pkg::ST_IDLE;
			status_valid_out <= 1'b0;
			status_check_out <= 1'b0;
			sense_key_out    <= `SODD_SK_NONE;
			asc_out          <= `SODD_ASC_NONE;
			dout_ready_out   <= 1'b0;
			remain_q         <= 41'h0;
			didx_q           <= 16'h0000;
			fc_q             <= `SODD_FC_NONE;
			nexus_q          <= '0;
		end else begin
			status_valid_out <= 1'b0;
			unique case (state_q)
				sodd_pkg::ST_IDLE: begin
					if (cdb_valid_in && cdb_last_in) begin
						state_q <= sodd_pkg::ST_DECODE;
						nexus_q <= cdb_nexus_in;
					end
				end
				sodd_pkg::ST_DECODE: begin
					status_check_out <= bad;
					sense_key_out    <= bad ? bad_sk : `SODD_SK_NONE;
					asc_out          <= bad ? bad_asc : `SODD_ASC_NONE;
					fc_q             <= fc;
					didx_q           <= 16'h0000;
					remain_q         <= xfer_len;
					if (bad) begin
						state_q <= sodd_pkg::ST_STATUS;
					end else if (op == `SODD_OP_SEC_OUT) begin
						dout_ready_out <= (xfer_len != 41'h0);
						state_q        <= (xfer_len != 41'h0) ? sodd_pkg::ST_SEC_DATA : sodd_pkg::ST_SEC_WAIT;
					end else if (selftest) begin
						state_q <= sodd_pkg::ST_TEST_WAIT;
					end else if (plen != 16'h0000) begin
						remain_q       <= {25'h0, plen};
						dout_ready_out <= 1'b1;
						state_q        <= sodd_pkg::ST_DIAG_DATA;
					end else begin
						state_q <= sodd_pkg::ST_ACT;
					end
				end
				sodd_pkg::ST_SEC_DATA, sodd_pkg::ST_DIAG_DATA: begin
					if (dacc) begin
						remain_q <= remain_q - 41'h1;
						didx_q   <= didx_q + 16'h0001;
						if (remain_q == 41'h1) begin
							dout_ready_out <= 1'b0;
							state_q        <= (state_q == sodd_pkg::ST_SEC_DATA) ?
								sodd_pkg::ST_SEC_WAIT : sodd_pkg::ST_DIAG_EVAL;
						end
					end
				end
				sodd_pkg::ST_SEC_WAIT: begin
					if (sec_early_good_in) begin
						state_q <= sodd_pkg::ST_STATUS;
					end else if (sec_done_in) begin
						status_check_out <= !sec_ok_in;
						sense_key_out    <= sec_ok_in ? `SODD_SK_NONE : `SODD_SK_ILLEGAL;
						asc_out          <= sec_ok_in ? `SODD_ASC_NONE : `SODD_ASC_INV_PARAM;
						state_q          <= sodd_pkg::ST_STATUS;
					end
				end
				sodd_pkg::ST_DIAG_EVAL: begin
					if (!page_match) begin
						status_check_out <= 1'b1;
						sense_key_out    <= `SODD_SK_ILLEGAL;
						asc_out          <= `SODD_ASC_INV_CDB;
						state_q          <= sodd_pkg::ST_STATUS;
					end else if (page_code_q != `SODD_PAGE_SUPPORT) begin
						status_check_out <= 1'b1;
						sense_key_out    <= `SODD_SK_ILLEGAL;
						asc_out          <= `SODD_ASC_INV_PARAM;
						state_q          <= sodd_pkg::ST_STATUS;
					end else begin
						state_q <= sodd_pkg::ST_ACT;
					end
				end
				sodd_pkg::ST_ACT: begin
					if (fc_q == `SODD_FC_FG_SHORT || fc_q == `SODD_FC_FG_EXT) begin
						state_q <= sodd_pkg::ST_TEST_WAIT;
					end else begin
						state_q <= sodd_pkg::ST_STATUS;
					end
				end
				sodd_pkg::ST_TEST_WAIT: begin
					if ((st_done_in && st_fault_in) || (fg_short_q && fg_cnt_q >= FG_SHORT_CYCLES)) begin
						status_check_out <= 1'b1;
						sense_key_out    <= `SODD_SK_HW_ERROR;
						asc_out          <= `SODD_ASC_TEST_FAIL;
						state_q          <= sodd_pkg::ST_STATUS;
					end else if (st_done_in) begin
						state_q <= sodd_pkg::ST_STATUS;
					end
				end
				sodd_pkg::ST_STATUS: begin
					status_valid_out <= 1'b1;
					state_q          <= sodd_pkg::ST_IDLE;
				end
				default: begin
					state_q <= sodd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Diagnostic page header capture; the offline flags play no part.
	always_ff @(posedge clk_in) begin
		if (rst_in || state_q == sodd_pkg::ST_DECODE) begin
			page_code_q <= 8'hff;
			page_len_q  <= `SODD_PAGE_LEN_NONE;
		end else if (dacc && state_q == sodd_pkg::ST_DIAG_DATA) begin
			if (didx_q == 16'h0000) begin
				page_code_q <= dout_byte_in;
			end else if (didx_q == 16'h0002) begin
				page_len_q[15:8] <= dout_byte_in;
			end else if (didx_q == 16'h0003) begin
				page_len_q[7:0] <= dout_byte_in;
			end
		end
	end

	// Security command start and parameter byte forwarding.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sec_start_out      <= 1'b0;
			sec_proto_out      <= 8'h00;
			sec_len_out        <= 41'h0;
			sec_byte_valid_out <= 1'b0;
			sec_byte_out       <= `SODD_PAD_BYTE;
		end else begin
			sec_start_out      <= state_q == sodd_pkg::ST_DECODE && !bad && op == `SODD_OP_SEC_OUT;
			sec_byte_valid_out <= dacc && state_q == sodd_pkg::ST_SEC_DATA;
			if (state_q == sodd_pkg::ST_DECODE && op == `SODD_OP_SEC_OUT) begin
				sec_proto_out <= b1;
				sec_len_out   <= xfer_len;
			end
			if (dacc) begin
				sec_byte_out <= dout_byte_in;
			end
		end
	end

	// Security results that end good in ST_SEC_WAIT stay held until read, unit reset or nexus loss.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sec_result_held_out <= 1'b0;
			held_nexus_q        <= '0;
		end else if (state_q == sodd_pkg::ST_SEC_WAIT && sec_done_in && sec_ok_in) begin
			sec_result_held_out <= 1'b1;
			held_nexus_q        <= nexus_q;
		end else if (lun_reset_in || (result_read_in && read_nexus_in == held_nexus_q)
				|| (nexus_loss_in && loss_nexus_in == held_nexus_q)) begin
			sec_result_held_out <= 1'b0;
		end
	end

	// Self-test start and abort requests.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_start_out      <= 1'b0;
			st_kind_out       <= sodd_pkg::TEST_DEFAULT;
			st_background_out <= 1'b0;
			st_abort_out      <= 1'b0;
			fg_short_q        <= 1'b0;
		end else begin
			st_start_out <= 1'b0;
			st_abort_out <= 1'b0;
			if (state_q == sodd_pkg::ST_DECODE && !bad && op == `SODD_OP_DIAG && selftest) begin
				st_start_out      <= 1'b1;
				st_kind_out       <= sodd_pkg::TEST_DEFAULT;
				st_background_out <= 1'b0;
				fg_short_q        <= 1'b0;
			end else if (state_q == sodd_pkg::ST_ACT) begin
				st_start_out      <= fc_q != `SODD_FC_NONE && fc_q != `SODD_FC_ABORT;
				st_abort_out      <= fc_q == `SODD_FC_ABORT;
				st_kind_out       <= (fc_q == `SODD_FC_BG_EXT || fc_q == `SODD_FC_FG_EXT) ?
					sodd_pkg::TEST_EXTENDED : sodd_pkg::TEST_SHORT;
				st_background_out <= fc_q == `SODD_FC_BG_SHORT || fc_q == `SODD_FC_BG_EXT;
				fg_short_q        <= fc_q == `SODD_FC_FG_SHORT;
			end
		end
	end

	// Foreground short test time limit counter.
	always_ff @(posedge clk_in) begin
		if (rst_in || state_q != sodd_pkg::ST_TEST_WAIT) begin
			fg_cnt_q <= 40'h0;
		end else if (fg_short_q) begin
			fg_cnt_q <= fg_cnt_q + 40'h1;
		end
	end

	// Background test tracking and fault logging.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bg_busy_q     <= 1'b0;
			log_valid_out <= 1'b0;
			log_kind_out  <= sodd_pkg::TEST_SHORT;
		end else begin
			log_valid_out <= 1'b0;
			if (st_start_out && st_background_out) begin
				bg_busy_q <= 1'b1;
			end else if (st_abort_out || (st_done_in && state_q != sodd_pkg::ST_TEST_WAIT)) begin
				bg_busy_q <= 1'b0;
			end
			if (bg_busy_q && st_done_in && st_fault_in && state_q != sodd_pkg::ST_TEST_WAIT) begin
				log_valid_out <= 1'b1;
				log_kind_out  <= st_kind_out;
			end
		end
	end

	assign bg_busy_out = bg_busy_q;

	// Supported pages request stays pending until results are fetched.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pages_pending_out <= 1'b0;
		end else if (state_q == sodd_pkg::ST_DIAG_EVAL && page_match && page_code_q == `SODD_PAGE_SUPPORT) begin
			pages_pending_out <= 1'b1;
		end else if (rcv_diag_in) begin
			pages_pending_out <= 1'b0;
		end
	end

	// Checks on the decoder's own behaviour.
	property p_sec_start;
		@(posedge clk_in) disable iff (rst_in)
		(state_q == sodd_pkg::ST_DECODE && op == `SODD_OP_SEC_OUT && !proto_reserved(b1))
			|=> sec_start_out && sec_len_out == $past(xfer_len);
	endproperty
	a_sec_start: assert property (p_sec_start) else $error("security start missing");

	property p_proto_ok;
		@(posedge clk_in) disable iff (rst_in)
		sec_start_out |-> sec_proto_out >= `SODD_PROTO_FIRST && sec_proto_out <= `SODD_PROTO_LAST;
	endproperty
	a_proto_ok: assert property (p_proto_ok) else $error("reserved protocol started");

	property p_early_good;
		@(posedge clk_in) disable iff (rst_in)
		(state_q == sodd_pkg::ST_SEC_WAIT && sec_early_good_in) |=> ##1 status_valid_out && !status_check_out;
	endproperty
	a_early_good: assert property (p_early_good) else $error("early good status missing");

	property p_len_nonzero;
		@(posedge clk_in) disable iff (rst_in)
		(state_q == sodd_pkg::ST_DECODE && op == `SODD_OP_DIAG && spin_ok_q && selftest && plen != 16'h0000)
			|=> ##1 status_valid_out && status_check_out && asc_out == `SODD_ASC_INV_CDB;
	endproperty
	a_len_nonzero: assert property (p_len_nonzero) else $error("nonzero length accepted");

	property p_not_ready;
		@(posedge clk_in) disable iff (rst_in)
		(state_q == sodd_pkg::ST_DECODE && op == `SODD_OP_DIAG && !spin_ok_q)
			|=> !st_start_out ##1 status_valid_out && sense_key_out == `SODD_SK_NOT_READY;
	endproperty
	a_not_ready: assert property (p_not_ready) else $error("not ready not reported");

	property p_fg_fault;
		@(posedge clk_in) disable iff (rst_in)
		(state_q == sodd_pkg::ST_TEST_WAIT && st_done_in && st_fault_in)
			|=> ##1 status_valid_out && status_check_out;
	endproperty
	a_fg_fault: assert property (p_fg_fault) else $error("test fault not reported");

	property p_bg_log;
		@(posedge clk_in) disable iff (rst_in)
		(bg_busy_q && st_done_in && st_fault_in && state_q == sodd_pkg::ST_IDLE) |=> log_valid_out;
	endproperty
	a_bg_log: assert property (p_bg_log) else $error("background fault not logged");

	property p_abort_idle;
		@(posedge clk_in) disable iff (rst_in)
		(state_q == sodd_pkg::ST_DECODE && op == `SODD_OP_DIAG && spin_ok_q && !selftest
			&& fc == `SODD_FC_ABORT && !bg_busy_q) |=> ##1 status_valid_out && status_check_out;
	endproperty
	a_abort_idle: assert property (p_abort_idle) else $error("stray abort accepted");

	property p_held;
		@(posedge clk_in) disable iff (rst_in)
		(sec_result_held_out && !lun_reset_in && !result_read_in && !nexus_loss_in) |=> sec_result_held_out;
	endproperty
	a_held: assert property (p_held) else $error("held result dropped");

endmodule : sodd_decoder

// ===== hdl/sodd_defs.svh
`ifndef SODD_DEFS_SVH
`define SODD_DEFS_SVH

// Operation codes held in byte 0 of a command block.
`define SODD_OP_SEC_OUT    8'hb5
`define SODD_OP_DIAG       8'h1d
`define SODD_CDB_BYTES     12

// Security protocol values that are defined; all others are reserved.
`define SODD_PROTO_FIRST   8'h01
`define SODD_PROTO_LAST    8'h06
`define SODD_INC512_BIT    7
`define SODD_BLOCK_SHIFT   9
`define SODD_PAD_BYTE      8'h00

// Diagnostic byte 1 field positions.
`define SODD_FC_HI         7
`define SODD_FC_LO         5
`define SODD_PF_BIT        4
`define SODD_SELFTEST_BIT  2
`define SODD_DEVICE_OFFLINE_FLAG_BIT    1
`define SODD_UNIT_OFFLINE_FLAG_BIT    0

// Diagnostic function codes.
`define SODD_FC_NONE       3'h0
`define SODD_FC_BG_SHORT   3'h1
`define SODD_FC_BG_EXT     3'h2
`define SODD_FC_RSVD_A     3'h3
`define SODD_FC_ABORT      3'h4
`define SODD_FC_FG_SHORT   3'h5
`define SODD_FC_FG_EXT     3'h6
`define SODD_FC_RSVD_B     3'h7

// Diagnostic page header.
`define SODD_PAGE_HDR      17'h00004
`define SODD_PAGE_SUPPORT  8'h00
`define SODD_PAGE_LEN_NONE 16'hffff

// Sense keys and additional sense codes.
`define SODD_SK_NONE       4'h0
`define SODD_SK_NOT_READY  4'h2
`define SODD_SK_HW_ERROR   4'h4
`define SODD_SK_ILLEGAL    4'h5
`define SODD_ASC_NONE      8'h00
`define SODD_ASC_NOT_READY 8'h04
`define SODD_ASC_INV_OP    8'h20
`define SODD_ASC_INV_CDB   8'h24
`define SODD_ASC_INV_PARAM 8'h26
`define SODD_ASC_TEST_FAIL 8'h40

// Foreground short self-test time limit.
`define SODD_FG_SHORT_S    64'd120
`define SODD_CLK_HZ        64'd100000000

`endif

// ===== hdl/sodd_pkg.sv
package sodd_pkg;

	// Command sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DECODE,
		ST_SEC_DATA,
		ST_SEC_WAIT,
		ST_DIAG_DATA,
		ST_DIAG_EVAL,
		ST_ACT,
		ST_TEST_WAIT,
		ST_STATUS
	} sodd_state_e;

	// Kind of self-test handed to the test engine.
	typedef enum logic [1:0] {
		TEST_DEFAULT,
		TEST_SHORT,
		TEST_EXTENDED
	} sodd_test_e;

endpackage : sodd_pkg

// ===== tb/sodd_far_model.sv
module sodd_far_model (
	// Clock, reset and fault choice.
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        fault_in,
	// Self-test engine side.
	input  wire logic        st_start_in,
	input  wire logic        st_background_in,
	input  wire logic        st_abort_in,
	output logic             st_done_out,
	output logic             st_fault_out,
	// Security handler side.
	input  wire logic        sec_start_in,
	input  wire logic        sec_byte_valid_in,
	input  wire logic [40:0] sec_len_in,
	output logic             sec_done_out,
	output logic             sec_ok_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0]  tmr_q;
	logic [40:0] cnt_q;

	// Background tests run longer so that an abort can still catch them.
	always_ff @(posedge clk_in) begin
		if (rst_in || st_abort_in) begin
			tmr_q <= 6'h00;
		end else if (st_start_in) begin
			tmr_q <= st_background_in ? 6'h28 : 6'h0a;
		end else if (tmr_q != 6'h00) begin
			tmr_q <= tmr_q - 6'h01;
		end
	end

	// A test ends with a one-cycle done, carrying the chosen fault; the same choice fails security processing.
	assign st_done_out  = (tmr_q == 6'h01);
	assign st_fault_out = fault_in & st_done_out;
	assign sec_ok_out   = !fault_in;

	// Processing ends one cycle after the last counted byte.
	always_ff @(posedge clk_in) begin
		if (rst_in || sec_start_in) begin
			cnt_q <= 41'h0;
		end else if (sec_byte_valid_in) begin
			cnt_q <= cnt_q + 41'h1;
		end
		sec_done_out <= !rst_in && sec_byte_valid_in && (cnt_q + 41'h1 == sec_len_in);
	end
endmodule : sodd_far_model

// ===== tb/testbench.sv
`include "sodd_defs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [12:0] GOOD = 13'h0000;
	localparam logic [12:0] BAD  = {1'b1, 4'h5, 8'h24};
	localparam logic [12:0] HW   = {1'b1, 4'h4, 8'h40};
	logic        clk = 0, rst = 1, cv = 0, cl = 0, dv = 0, early = 0, spin = 1, rr = 0, lr = 0, rd = 0, flt = 0;
	logic [7:0]  cb = 8'h00, db = 8'h00;
	logic        nl = 0;
	logic [7:0]  rp [3] = '{8'h00, 8'h07, 8'hff};
	logic        dr, sv, sc, ss, sb, sa, bg, lv, tdn, tfl, sdn, sok, sst, sbv, held, pend;
	logic [3:0]  sk;
	logic [7:0]  asc, sp, sby;
	logic [40:0] sl;
	logic [12:0] res;
	sodd_pkg::sodd_test_e kd, kind, lk;
	int          nst = 0, nlog = 0, nab = 0, err_total = 0, checked = 0;

	always #5 clk = ~clk;

	sodd_decoder #(.FG_SHORT_CYCLES(40'd8)) i_dut (
		.clk_in(clk), .rst_in(rst), .cdb_valid_in(cv), .cdb_byte_in(cb), .cdb_last_in(cl), .cdb_nexus_in(8'h00),
		.dout_valid_in(dv), .dout_byte_in(db), .dout_ready_out(dr),
		.status_valid_out(sv), .status_check_out(sc), .sense_key_out(sk), .asc_out(asc),
		.sec_start_out(sst), .sec_proto_out(sp), .sec_len_out(sl), .sec_byte_valid_out(sbv), .sec_byte_out(sby),
		.sec_early_good_in(early), .sec_done_in(sdn), .sec_ok_in(sok), .result_read_in(rr),
		.read_nexus_in(8'h00), .lun_reset_in(lr), .nexus_loss_in(nl), .loss_nexus_in(8'h00),
		.sec_result_held_out(held), .spindle_ok_in(spin), .st_start_out(ss), .st_kind_out(kd),
		.st_background_out(sb), .st_abort_out(sa), .st_done_in(tdn), .st_fault_in(tfl), .bg_busy_out(bg),
		.log_valid_out(lv), .log_kind_out(lk), .rcv_diag_in(rd), .pages_pending_out(pend));

	sodd_far_model i_far (.clk_in(clk), .rst_in(rst), .fault_in(flt), .st_start_in(ss), .st_background_in(sb),
		.st_abort_in(sa), .st_done_out(tdn), .st_fault_out(tfl), .sec_start_in(sst), .sec_byte_valid_in(sbv),
		.sec_len_in(sl), .sec_done_out(sdn), .sec_ok_out(sok));

	// Captures status, test kind, aborts and log entries as they pulse.
	always @(posedge clk) begin
		if (sv) begin
			res <= {sc, sk, asc};
			nst <= nst + 1;
		end
		if (ss) kind <= kd;
		if (sa) nab <= nab + 1;
		if (lv) nlog <= nlog + 1;
	end

	task automatic check(input string n, input logic [40:0] v, input logic [40:0] e);
		checked++;
		if (v !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, v);
		end
	endtask : check

	task automatic complete_run();
		if (err_total == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run

	// Sends a command block, offers data bytes holding the current db value until status, then compares the status.
	task automatic cmd(input logic [95:0] c, input int n, input logic [12:0] e);
		int i;
		int k;
		k = nst;
		for (i = 0; i < n; i++) begin
			cv <= 1'b1;
			cb <= c[95-8*i -: 8];
			cl <= (i == n - 1);
			@(posedge clk);
		end
		cv <= 1'b0;
		cl <= 1'b0;
		dv <= 1'b1;
		for (i = 0; i < 3000 && nst == k; i++) @(posedge clk);
		dv <= 1'b0;
		if (nst == k) begin
			err_total++;
			complete_run();
		end else begin
			check("status", res, e);
		end
	endtask : cmd

	task automatic diag(input logic [7:0] b1, input logic [15:0] len, input logic [12:0] e);
		cmd({`SODD_OP_DIAG, b1, 8'h00, len, 8'h00, 48'h0}, 6, e);
	endtask : diag

	task automatic sec(input logic [7:0] p, input logic [7:0] inc, input logic [31:0] len, input logic [12:0] e);
		cmd({`SODD_OP_SEC_OUT, p, 16'h0, inc, 8'h00, len, 16'h0}, 12, e);
	endtask : sec

	// Main sequence of commands and their expected outcomes.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		diag(8'hf7, 16'h0000, GOOD);
		check("kind", kind, sodd_pkg::TEST_DEFAULT);
		diag(8'h04, 16'h0001, BAD);
		diag(8'h60, 16'h0000, BAD);
		diag(8'he0, 16'h0000, BAD);
		diag(8'h80, 16'h0000, BAD);
		diag(8'h23, 16'h0000, GOOD);
		check("busy", bg, 1);
		diag(8'h80, 16'h0000, GOOD);
		check("aborts", nab, 1);
		diag(8'ha0, 16'h0000, HW);
		check("kind", kind, sodd_pkg::TEST_SHORT);
		flt <= 1'b1;
		diag(8'hc0, 16'h0000, HW);
		diag(8'h40, 16'h0000, GOOD);
		repeat (60) @(posedge clk);
		check("log", nlog, 1);
		check("log kind", lk, sodd_pkg::TEST_EXTENDED);
		flt <= 1'b0;
		spin <= 1'b0;
		repeat (4) @(posedge clk);
		diag(8'h04, 16'h0000, {1'b1, 4'h2, 8'h04});
		spin <= 1'b1;
		repeat (4) @(posedge clk);
		cmd({8'h00, 88'h0}, 6, {1'b1, 4'h5, 8'h20});
		diag(8'h10, 16'h0004, GOOD);
		check("pending", pend, 1);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		check("pending", pend, 0);
		diag(8'h10, 16'h0005, BAD);
		db <= 8'h01;
		diag(8'h10, 16'h0105, {1'b1, 4'h5, 8'h26});
		db <= 8'ha5;
		for (int p = 0; p < 3; p++) sec(rp[p], 8'h00, 32'h1, BAD);
		early <= 1'b1;
		sec(8'h01, 8'h00, 32'h3, GOOD);
		check("length", sl, 41'h3);
		check("byte", sby, 8'ha5);
		early <= 1'b0;
		db <= 8'h00;
		sec(8'h06, 8'h80, 32'h1, GOOD);
		check("length", sl, 41'h200);
		check("protocol", sp, 8'h06);
		check("held", held, 1);
		rr <= 1'b1;
		@(posedge clk);
		rr <= 1'b0;
		@(posedge clk);
		check("held", held, 0);
		sec(8'h02, 8'h00, 32'h2, GOOD);
		check("held", held, 1);
		lr <= 1'b1;
		@(posedge clk);
		lr <= 1'b0;
		@(posedge clk);
		check("held", held, 0);
		sec(8'h04, 8'h00, 32'h1, GOOD);
		check("held", held, 1);
		nl <= 1'b1;
		@(posedge clk);
		nl <= 1'b0;
		@(posedge clk);
		check("held", held, 0);
		flt <= 1'b1;
		sec(8'h03, 8'h00, 32'h1, {1'b1, 4'h5, 8'h26});
		check("held", held, 0);
		complete_run();
	end
endmodule : testbench
